/* rtl/ptp_clock_control_map.svh */
// register offsets, field positions and timing constants of the precision clock control
// Function
// - step-adjust bit adds or subtracts the nanosecond value from the clock, then self-clears
// - step direction one means add, zero means subtract
// - snapshot bit captures live time into the time registers, then self-clears
// - load bit copies the time registers into the live clock, then self-clears
// - continuous adjust shifts frequency by rate every 25 MHz cycle, direction selectable
// - continuous-adjust bit at zero means no frequency adjustment
// - clock enable resets to one; zero freezes the clock
// - clock-reset bit resets the clock and self-clears
// - nanosecond low word holds bits 15:0, read and write
// - nanosecond high word bits 15:14 are unused
// - nanosecond high word bits 13:0 hold nanosecond bits 29:16
// - seconds are 32 bits split in low and high 16-bit words
// - sub-phase gives 8 ns slot in 40 ns; cleared by any time register write
// - rate in units of 2^-32 ns, applied per 40 ns; zero disables
`ifndef PTP_CLOCK_CONTROL_MAP_SVH
`define PTP_CLOCK_CONTROL_MAP_SVH
// ==========================================
// register offsets
`define OFS_CTL 11'h600
`define OFS_NSL 11'h604
`define OFS_NSH 11'h606
`define OFS_SL 11'h608
`define OFS_SH 11'h60A
`define OFS_PHASE 11'h60C
`define OFS_RATE_L 11'h610
`define OFS_RATE_H 11'h612
// ==========================================
// control bit positions
`define BIT_STEP_GO 6
`define BIT_STEP_DIR 5
`define BIT_SNAP_GO 4
`define BIT_LOAD_GO 3
`define BIT_CONT_EN 2
`define BIT_RUN_EN 1
`define BIT_RST_GO 0
`define BIT_RATE_DIR 15
`define RUN_EN_RESET 1'h1
// ==========================================
// timing
`define CLK_PERIOD_NS 8
`define REF_PERIOD_NS 40
`define PHASE_LAST 3'((`REF_PERIOD_NS / `CLK_PERIOD_NS) - 1)
`define NS_PER_TICK 31'(`REF_PERIOD_NS)
`define NS_WRAP 31'h3B9ACA00
`endif

/* rtl/ptp_clock_control_pkg.sv */
// types shared by the precision clock control
package ptp_clock_control_pkg;
	typedef logic [31:0] sec_t;
	typedef logic [29:0] nsec_t;
	typedef logic [2:0] phase_t;
	typedef logic [29:0] rate_t;
endpackage

/* rtl/ptp_clock_control.sv */
// precision time clock: control register, live time, shadow time and rate adjust
`timescale 1ns/100ps
`default_nettype none
`include "ptp_clock_control_map.svh"
module ptp_clock_control
	import ptp_clock_control_pkg::*;
(
	input wire logic core_clk,
	input wire logic sys_rst,
	input wire logic [10:0] reg_addr,
	input wire logic reg_wr,
	input wire logic reg_rd,
	input wire logic [15:0] reg_wdata,
	output logic [15:0] reg_rdata,
	output sec_t live_seconds,
	output nsec_t live_nanoseconds,
	output phase_t live_sub_phase
);

// ==========================================
// control register
logic step_go_reg;
logic step_dir_reg;
logic snap_go_reg;
logic load_go_reg;
logic cont_en_reg;
logic run_en_reg;
logic rst_go_reg;
logic wr_ctl;

assign wr_ctl = reg_wr && (reg_addr == `OFS_CTL);

// go bits live exactly one cycle: set by the write, cleared as the action lands
always_ff @(posedge core_clk)
begin
	if (sys_rst)
	begin
		step_go_reg <= 1'b0;
		snap_go_reg <= 1'b0;
		load_go_reg <= 1'b0;
		rst_go_reg <= 1'b0;
	end
	else
	begin
		step_go_reg <= wr_ctl && reg_wdata[`BIT_STEP_GO];
		snap_go_reg <= wr_ctl && reg_wdata[`BIT_SNAP_GO];
		load_go_reg <= wr_ctl && reg_wdata[`BIT_LOAD_GO];
		rst_go_reg <= wr_ctl && reg_wdata[`BIT_RST_GO];
	end
end

always_ff @(posedge core_clk)
begin
	if (sys_rst)
	begin
		step_dir_reg <= 1'b0;
		cont_en_reg <= 1'b0;
		run_en_reg <= `RUN_EN_RESET;
	end
	else if (wr_ctl)
	begin
		step_dir_reg <= reg_wdata[`BIT_STEP_DIR];
		cont_en_reg <= reg_wdata[`BIT_CONT_EN];
		run_en_reg <= reg_wdata[`BIT_RUN_EN];
	end
end

// ==========================================
// rate registers
logic [15:0] rate_lo_reg;
logic [13:0] rate_hi_reg;
logic rate_dir_reg;
rate_t rate;

assign rate = {rate_hi_reg, rate_lo_reg};

always_ff @(posedge core_clk)
begin
	if (sys_rst)
	begin
		rate_lo_reg <= 16'h0000;
		rate_hi_reg <= 14'h0000;
		rate_dir_reg <= 1'b0;
	end
	else if (reg_wr && (reg_addr == `OFS_RATE_L))
		rate_lo_reg <= reg_wdata;
	else if (reg_wr && (reg_addr == `OFS_RATE_H))
	begin
		rate_hi_reg <= reg_wdata[13:0];
		rate_dir_reg <= reg_wdata[`BIT_RATE_DIR];
	end
end

// ==========================================
// shadow time registers seen by the host
sec_t sec_sh_reg;
nsec_t ns_sh_reg;
phase_t ph_sh_reg;
sec_t sec_reg;
nsec_t ns_reg;
phase_t ph_reg;
logic wr_time;

assign wr_time = reg_wr && ((reg_addr == `OFS_NSL) || (reg_addr == `OFS_NSH)
	|| (reg_addr == `OFS_SL) || (reg_addr == `OFS_SH));

// snapshot wins over a host write in the same cycle
always_ff @(posedge core_clk)
begin
	if (sys_rst)
	begin
		sec_sh_reg <= 32'h0000_0000;
		ns_sh_reg <= 30'h0000_0000;
		ph_sh_reg <= 3'h0;
	end
	else if (snap_go_reg)
	begin
		sec_sh_reg <= sec_reg;
		ns_sh_reg <= ns_reg;
		ph_sh_reg <= ph_reg;
	end
	else if (reg_wr)
	begin
		if (reg_addr == `OFS_NSL)
			ns_sh_reg[15:0] <= reg_wdata;
		if (reg_addr == `OFS_NSH)
			ns_sh_reg[29:16] <= reg_wdata[13:0];
		if (reg_addr == `OFS_SL)
			sec_sh_reg[15:0] <= reg_wdata;
		if (reg_addr == `OFS_SH)
			sec_sh_reg[31:16] <= reg_wdata;
		if (wr_time)
			ph_sh_reg <= 3'h0;
		else if (reg_addr == `OFS_PHASE)
			ph_sh_reg <= reg_wdata[2:0];
	end
end

// ==========================================
// rate accumulator and advance
logic [31:0] frac_reg;
logic [32:0] frac_sum;
logic tick;
logic adj_on;
logic carry;
logic [30:0] adv_ns;
logic [30:0] step_add;
logic step_borrow;
logic [30:0] step_sub;

assign tick = run_en_reg && (ph_reg == `PHASE_LAST);
assign adj_on = cont_en_reg && (rate != 30'h0000_0000);
// fraction in 2^-32 ns; a wrap of it is one whole nanosecond
assign frac_sum = rate_dir_reg ? ({1'b0, frac_reg} - {3'h0, rate})
	: ({1'b0, frac_reg} + {3'h0, rate});
assign carry = adj_on && frac_sum[32];
assign adv_ns = {1'b0, ns_reg} + `NS_PER_TICK + {30'h0, carry && !rate_dir_reg}
	- {30'h0, carry && rate_dir_reg};
assign step_add = {1'b0, ns_reg} + {1'b0, ns_sh_reg};
assign step_borrow = ns_sh_reg > ns_reg;
// a borrowed second puts the difference back into range
assign step_sub = {1'b0, ns_reg} - {1'b0, ns_sh_reg} + (step_borrow ? `NS_WRAP : 31'h0);

always_ff @(posedge core_clk)
begin
	if (sys_rst)
		frac_reg <= 32'h0000_0000;
	else if (tick && adj_on)
		frac_reg <= frac_sum[31:0];
end

// ==========================================
// live clock
sec_t sec_next;
nsec_t ns_next;
phase_t ph_next;

always_comb
begin
	sec_next = sec_reg;
	ns_next = ns_reg;
	ph_next = ph_reg;
	if (run_en_reg)
	begin
		ph_next = tick ? 3'h0 : 3'(ph_reg + 3'h1);
		if (tick)
		begin
			if (adv_ns >= `NS_WRAP)
			begin
				ns_next = 30'(adv_ns - `NS_WRAP);
				sec_next = sec_reg + 32'h1;
			end
			else
				ns_next = adv_ns[29:0];
		end
	end
	if (rst_go_reg)
	begin
		sec_next = 32'h0000_0000;
		ns_next = 30'h0000_0000;
		ph_next = 3'h0;
	end
	else if (load_go_reg)
	begin
		sec_next = sec_sh_reg;
		ns_next = ns_sh_reg;
		ph_next = ph_sh_reg;
	end
	else if (step_go_reg && step_dir_reg)
	begin
		if (step_add >= `NS_WRAP)
		begin
			ns_next = 30'(step_add - `NS_WRAP);
			sec_next = sec_reg + 32'h1;
		end
		else
			ns_next = step_add[29:0];
	end
	else if (step_go_reg)
	begin
		ns_next = step_sub[29:0];
		sec_next = step_borrow ? sec_reg - 32'h1 : sec_reg;
	end
end

always_ff @(posedge core_clk)
begin
	if (sys_rst)
	begin
		sec_reg <= 32'h0000_0000;
		ns_reg <= 30'h0000_0000;
		ph_reg <= 3'h0;
	end
	else
	begin
		sec_reg <= sec_next;
		ns_reg <= ns_next;
		ph_reg <= ph_next;
	end
end

assign live_seconds = sec_reg;
assign live_nanoseconds = ns_reg;
assign live_sub_phase = ph_reg;

// ==========================================
// read back, one cycle after the read strobe
always_ff @(posedge core_clk)
begin
	if (sys_rst)
		reg_rdata <= 16'h0000;
	else if (reg_rd)
	begin
		case (reg_addr)
			`OFS_CTL: reg_rdata <= {9'h000, step_go_reg, step_dir_reg, snap_go_reg,
				load_go_reg, cont_en_reg, run_en_reg, rst_go_reg};
			`OFS_NSL: reg_rdata <= ns_sh_reg[15:0];
			`OFS_NSH: reg_rdata <= {2'h0, ns_sh_reg[29:16]};
			`OFS_SL: reg_rdata <= sec_sh_reg[15:0];
			`OFS_SH: reg_rdata <= sec_sh_reg[31:16];
			`OFS_PHASE: reg_rdata <= {13'h0000, ph_sh_reg};
			`OFS_RATE_L: reg_rdata <= rate_lo_reg;
			`OFS_RATE_H: reg_rdata <= {rate_dir_reg, 1'b0, rate_hi_reg};
			default: reg_rdata <= 16'h0000;
		endcase
	end
end

// ==========================================
// checks
logic no_go;
logic plain_tick;

assign no_go = !(step_go_reg || load_go_reg || rst_go_reg);
assign plain_tick = tick && no_go && ({1'b0, ns_reg} + `NS_PER_TICK + 31'h1 < `NS_WRAP);

a_step_clears:
assert property (@(posedge core_clk) disable iff (sys_rst)
	step_go_reg |=> !step_go_reg)
	else $error("step go bit did not self-clear");

a_step_add_dir:
assert property (@(posedge core_clk) disable iff (sys_rst)
	step_go_reg && step_dir_reg && !load_go_reg && !rst_go_reg && (step_add < `NS_WRAP)
	|=> ns_reg == 30'($past(ns_reg) + $past(ns_sh_reg)))
	else $error("step add gave wrong nanoseconds");

a_snap_capture:
assert property (@(posedge core_clk) disable iff (sys_rst)
	snap_go_reg |=> (ns_sh_reg == $past(ns_reg)) && (sec_sh_reg == $past(sec_reg)))
	else $error("snapshot did not capture live time");

a_load_copy:
assert property (@(posedge core_clk) disable iff (sys_rst)
	load_go_reg && !rst_go_reg
	|=> (ns_reg == $past(ns_sh_reg)) && (sec_reg == $past(sec_sh_reg)))
	else $error("load did not copy shadow time");

a_adj_rate:
assert property (@(posedge core_clk) disable iff (sys_rst)
	plain_tick && adj_on && !rate_dir_reg
	|=> (ns_reg == 30'($past(ns_reg) + 30'h28)) || (ns_reg == 30'($past(ns_reg) + 30'h29)))
	else $error("adjusted tick out of range");

a_adj_off:
assert property (@(posedge core_clk) disable iff (sys_rst)
	plain_tick && !cont_en_reg |=> ns_reg == 30'($past(ns_reg) + 30'h28) ##0 $stable(frac_reg))
	else $error("adjustment applied while disabled");

a_clock_frozen:
assert property (@(posedge core_clk) disable iff (sys_rst)
	!run_en_reg && no_go |=> $stable(ns_reg) && $stable(ph_reg) && $stable(sec_reg))
	else $error("frozen clock moved");

a_reset_clear:
assert property (@(posedge core_clk) disable iff (sys_rst)
	rst_go_reg |=> (ns_reg == 30'h0) && (sec_reg == 32'h0) && (ph_reg == 3'h0))
	else $error("clock reset did not clear time");

a_nsh_read:
assert property (@(posedge core_clk) disable iff (sys_rst)
	reg_rd && (reg_addr == `OFS_NSH)
	|=> (reg_rdata[15:14] == 2'h0) && (reg_rdata[13:0] == $past(ns_sh_reg[29:16])))
	else $error("nanosecond high word read wrong");

a_phase_wrclr:
assert property (@(posedge core_clk) disable iff (sys_rst)
	wr_time && !snap_go_reg |=> ph_sh_reg == 3'h0)
	else $error("time write left sub-phase set");

a_wrap_carry:
assert property (@(posedge core_clk) disable iff (sys_rst)
	tick && no_go && !adj_on && (adv_ns >= `NS_WRAP)
	|=> sec_reg == $past(sec_reg) + 32'h1)
	else $error("nanosecond wrap missed carry");

endmodule
`default_nettype wire

/* tb/tb_ptp_clock_control.sv */
// self-checking bench for the precision clock control
`timescale 1ns/100ps
`default_nettype none
`include "ptp_clock_control_map.svh"
module tb_ptp_clock_control
	import ptp_clock_control_pkg::*;
;
	typedef struct {bit rd; bit pon; logic [15:0] d; sec_t s; nsec_t n; phase_t p;} note_t;
	note_t q[$];
	logic core_clk, sys_rst, reg_wr, reg_rd, smp, rd_q;
	logic [10:0] reg_addr;
	logic [15:0] reg_wdata, reg_rdata;
	sec_t live_seconds, s0;
	nsec_t live_nanoseconds, n0, n1, n2;
	phase_t live_sub_phase, p0;
	int num_errors, checked, k;
	longint f, e, dl;
	logic [10:0] zaddr [9] = '{11'h604, 11'h606, 11'h608, 11'h60A, 11'h60C, 11'h610, 11'h612,
		11'h602, 11'h60E};

	ptp_clock_control DUT (.core_clk(core_clk), .sys_rst(sys_rst), .reg_addr(reg_addr),
		.reg_wr(reg_wr), .reg_rd(reg_rd), .reg_wdata(reg_wdata), .reg_rdata(reg_rdata),
		.live_seconds(live_seconds), .live_nanoseconds(live_nanoseconds),
		.live_sub_phase(live_sub_phase));

	initial
	begin
		core_clk = 0;
		forever #4 core_clk = ~core_clk;
	end

	// ==========================================
	// compare side
	task automatic bad(string w, logic [64:0] x, logic [64:0] y);
		num_errors++;
		$display("CHECK FAILED %s expected %0h seen %0h", w, x, y);
	endtask
	task automatic cmp_rd(note_t t);
		checked++;
		if (reg_rdata !== t.d)
			bad("reg_rdata", 65'(t.d), 65'(reg_rdata));
	endtask
	task automatic cmp_live(note_t t);
		checked++;
		if (live_seconds !== t.s || live_nanoseconds !== t.n || (t.pon && live_sub_phase !== t.p))
			bad("live time", {t.p, t.s, t.n}, {live_sub_phase, live_seconds, live_nanoseconds});
	endtask
	// read data lands one edge after the strobe, so the strobe is remembered
	initial
	forever
	begin
		@(posedge core_clk);
		#1;
		if (rd_q)
			cmp_rd(q.pop_front());
		if (smp)
			cmp_live(q.pop_front());
		rd_q = reg_rd;
	end

	// ==========================================
	// drive side
	task automatic wr(logic [10:0] a, logic [15:0] d);
		@(negedge core_clk);
		reg_addr = a;
		reg_wdata = d;
		reg_wr = 1;
		@(negedge core_clk);
		reg_wr = 0;
	endtask
	task automatic rd(logic [10:0] a, logic [15:0] d);
		note_t t;
		t = '{1, 0, d, 0, 0, 0};
		@(negedge core_clk);
		reg_addr = a;
		reg_rd = 1;
		q.push_back(t);
		@(negedge core_clk);
		reg_rd = 0;
	endtask
	// live time is only sampled while frozen, so one cycle of lag is harmless
	task automatic lv(sec_t s, nsec_t n, phase_t p, bit pon);
		note_t t;
		t = '{0, pon, 0, s, n, p};
		@(negedge core_clk);
		q.push_back(t);
		smp = 1;
		@(negedge core_clk);
		smp = 0;
	endtask
	task automatic idle(int n);
		repeat (n) @(negedge core_clk);
	endtask
	task automatic finish_test;
		$display("errors %0d checks %0d", num_errors, checked);
		if (num_errors == 0 && checked > 0)
			$display("Simulation passed");
		else
			$display("Simulation failed");
		$finish;
	endtask

	initial
	begin
		#200000;
		num_errors++;
		finish_test;
	end

	// ==========================================
	// tests
	initial
	begin
		{reg_wr, reg_rd, smp, rd_q} = 4'h0;
		reg_addr = 11'h000;
		reg_wdata = 16'h0000;
		sys_rst = 1;
		num_errors = 0;
		checked = 0;
		f = 0;
		void'($urandom(32'hF1012DBC));
		repeat (3) @(posedge core_clk);
		@(negedge core_clk);
		sys_rst = 0;
		rd(`OFS_CTL, 16'h0002);
		foreach (zaddr[i])
			rd(zaddr[i], 16'h0000);
		$display("test reset done");
		s0 = $urandom & 32'h7FFFFFFF;
		n0 = 30'(999999999 - $urandom_range(19, 0));
		p0 = 3'($urandom_range(4, 1));
		wr(`OFS_SL, s0[15:0]);
		wr(`OFS_SH, s0[31:16]);
		wr(`OFS_NSH, {2'h0, n0[29:16]});
		wr(`OFS_PHASE, {13'h0, p0});
		wr(`OFS_NSL, n0[15:0]);
		rd(`OFS_PHASE, 16'h0000);
		wr(`OFS_PHASE, {13'h0, p0});
		rd(`OFS_PHASE, {13'h0, p0});
		rd(`OFS_NSH, {2'h0, n0[29:16]});
		// load while stopped, so the loaded value must stay put
		wr(`OFS_CTL, 16'h0008);
		idle(4);
		lv(s0, n0, p0, 1);
		idle(20);
		lv(s0, n0, p0, 1);
		$display("test load done");
		wr(`OFS_NSL, 16'h0028);
		wr(`OFS_NSH, 16'h0000);
		wr(`OFS_CTL, 16'h0060);
		idle(4);
		n1 = 30'(n0 + 40 - `NS_WRAP);
		lv(s0 + 1, n1, 0, 0);
		wr(`OFS_NSL, 16'h0032);
		wr(`OFS_CTL, 16'h0040);
		idle(4);
		n2 = 30'(n1 + `NS_WRAP - 50);
		lv(s0, n2, 0, 0);
		rd(`OFS_CTL, 16'h0000);
		$display("test step done");
		wr(`OFS_CTL, 16'h0010);
		idle(2);
		rd(`OFS_CTL, 16'h0000);
		rd(`OFS_SL, s0[15:0]);
		rd(`OFS_SH, s0[31:16]);
		rd(`OFS_NSL, n2[15:0]);
		rd(`OFS_NSH, {2'h0, n2[29:16]});
		$display("test snapshot done");
		// running wrap: load lands on edge 2, the tick on edge 7, stop after edge 9
		wr(`OFS_NSH, {2'h0, n0[29:16]});
		wr(`OFS_NSL, n0[15:0]);
		wr(`OFS_CTL, 16'h000A);
		idle(6);
		wr(`OFS_CTL, 16'h0000);
		idle(4);
		lv(s0 + 1, n1, 3'h2, 1);
		// forward step that stays inside one second
		wr(`OFS_NSL, 16'h0028);
		wr(`OFS_NSH, 16'h0000);
		wr(`OFS_CTL, 16'h0060);
		idle(4);
		lv(s0 + 1, 30'(n1 + 40), 3'h2, 1);
		$display("test wrap done");
		// pass 0 runs unadjusted, 1 speeds up, 2 slows down; fraction carries over
		wr(`OFS_RATE_L, 16'hFFFF);
		for (int m = 0; m < 3; m++)
		begin
			wr(`OFS_RATE_H, m == 2 ? 16'hBFFF : 16'h3FFF);
			rd(`OFS_RATE_H, m == 2 ? 16'hBFFF : 16'h3FFF);
			wr(`OFS_CTL, 16'h0001);
			idle(4);
			lv(0, 0, 0, 1);
			wr(`OFS_CTL, m > 0 ? 16'h0006 : 16'h0002);
			idle(60 + m * 7);
			wr(`OFS_CTL, 16'h0000);
			idle(4);
			// run edges 2..63+7m after the start write; ticks on edge 6, then every 5th
			k = (m == 2) ? 15 : 12 + m;
			dl = longint'(k) * (m > 0 ? 64'h3FFFFFFF : 64'h0);
			if (m == 2)
				dl = -dl;
			e = 40 * k + ((f + dl) >>> 32);
			f = (f + dl) & 64'hFFFFFFFF;
			lv(0, 30'(e), 0, 0);
		end
		$display("test rate done");
		finish_test;
	end
endmodule
`default_nettype wire
